/* logic/spi_port_with_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
    parameter int DEPTH = 8,
    parameter int W     = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clr,
    input  wire logic [3:0]   limit,
    input  wire logic         push,
    input  wire logic [W-1:0] din,
    input  wire logic         pop,
    output logic      [W-1:0] dout,
    output logic      [3:0]   count
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [3:0]    cnt_reg;
    logic          do_push;
    logic          do_pop;

    // Pushes beyond the active limit are dropped here
    assign do_push = push && (cnt_reg < limit);
    assign do_pop  = pop && (cnt_reg != 4'h0);
    assign dout    = mem[rp_reg];
    assign count   = cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= 4'h0;
        end else if (clr) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= 4'h0;
        end else begin
            if (do_push) wp_reg <= AW'(wp_reg + 1'b1);
            if (do_pop) rp_reg <= AW'(rp_reg + 1'b1);
            cnt_reg <= 4'(cnt_reg + {3'h0, do_push} - {3'h0, do_pop});
        end
    end

    // Storage has no reset: an empty buffer still shows whatever word sits at its read slot
    always_ff @(posedge clk) begin
        if (do_push) mem[wp_reg] <= din;
    end
endmodule // word_fifo

module spi_port_with_fifo #(
    parameter int DEPTH = spi_port_pkg::FIFO_DEPTH
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_N,
    input  wire logic                      IDLE_MODE,
    input  wire logic [7:0]                AWADDR,
    input  wire logic                      AWVALID,
    output logic                           AWREADY,
    input  wire logic [31:0]               WDATA,
    input  wire logic [3:0]                WSTRB,
    input  wire logic                      WVALID,
    output logic                           WREADY,
    output logic [1:0]                     BRESP,
    output logic                           BVALID,
    input  wire logic                      BREADY,
    input  wire logic [7:0]                ARADDR,
    input  wire logic                      ARVALID,
    output logic                           ARREADY,
    output logic [31:0]                    RDATA,
    output logic [1:0]                     RRESP,
    output logic                           RVALID,
    input  wire logic                      RREADY,
    input  wire logic                      SHIFT_CLOCK_PIN_IN,
    input  wire logic                      SERIAL_IN_PIN,
    input  wire logic                      SELECT_SYNC_PIN_IN,
    output spi_port_pkg::pin_out_type      PINS,
    output logic                           EVENT_OUT
);
    import spi_port_pkg::*;

    logic [1:0]    rst_sync_reg;
    logic          rst_n;
    logic [15:0]   con1_reg;
    logic [15:0]   con2_reg;
    logic          port_on_reg;
    logic          idle_halt_reg;
    logic [2:0]    sel_reg;
    logic          rx_overflow_reg;
    logic          aw_hold_reg;
    logic          w_hold_reg;
    logic [7:0]    awaddr_reg;
    logic [15:0]   wdata_reg;
    logic [1:0]    wstrb_reg;
    logic          wr_fire;
    logic          rd_take;
    logic          rd_pop;
    logic [15:0]   bm;
    logic [1:0]    sck_sync_reg;
    logic          sck_prev_reg;
    logic [1:0]    sdi_sync_reg;
    logic [1:0]    ss_sync_reg;
    eng_state_type state_reg;
    logic [8:0]    div_cnt_reg;
    logic [5:0]    half_cnt_reg;
    logic [15:0]   sh_tx_reg;
    logic [15:0]   sh_rx_reg;
    logic          sck_act_reg;
    logic          first_reg;
    logic          frame_arm_reg;
    logic          done_reg;
    logic          run;
    logic          master;
    logic          cke;
    logic          cpol;
    logic          sample_phase;
    logic          framed;
    logic          fsd;
    logic          fifo_on;
    logic [3:0]    limit;
    logic [5:0]    nbits;
    logic [5:0]    n;
    logic          tick;
    logic          sync_seen;
    logic          selected;
    logic          load;
    logic          s_lead;
    logic          s_trail;
    logic          chg;
    logic          smpl;
    logic          done;
    logic [6:0]    pri;
    logic [3:0]    sec;
    logic [9:0]    div;
    logic [8:0]    halfp;
    logic [15:0]   tx_dout;
    logic [15:0]   rx_dout;
    logic [3:0]    tx_cnt;
    logic [3:0]    rx_cnt;
    logic          tx_full;
    logic          rx_full;
    logic [3:0]    bec_src;
    logic [2:0]    bec;
    logic [15:0]   stat_word;
    logic          ev;

    // Reset is released through two flops so all logic leaves reset together
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) rst_sync_reg <= 2'b00;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // Pin inputs cross in through two flops; sck_prev only follows the second
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sck_sync_reg <= 2'b00;
            sck_prev_reg <= 1'b0;
            sdi_sync_reg <= 2'b00;
            ss_sync_reg  <= 2'b11;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], SHIFT_CLOCK_PIN_IN};
            sck_prev_reg <= sck_sync_reg[1];
            sdi_sync_reg <= {sdi_sync_reg[0], SERIAL_IN_PIN};
            ss_sync_reg  <= {ss_sync_reg[0], SELECT_SYNC_PIN_IN};
        end
    end

    // Configuration decode
    assign run     = port_on_reg && !(idle_halt_reg && IDLE_MODE);
    assign master  = con1_reg[B_MST];
    assign cke     = con1_reg[B_CKE];
    assign cpol    = con1_reg[B_CKP];
    assign sample_phase     = con1_reg[B_SMP] && master;
    assign framed  = con2_reg[B_FRM];
    assign fsd     = con2_reg[B_FSD];
    assign fifo_on = con2_reg[B_BEN];
    assign limit   = fifo_on ? 4'(DEPTH) : 4'h1;
    assign nbits   = con1_reg[B_WIDE] ? 6'd16 : 6'd8;
    assign n       = 6'(half_cnt_reg + 1'b1);
    assign tx_full = (tx_cnt == limit);
    assign rx_full = (rx_cnt == limit);

    // Prescalers; an odd product rounds the half period down, except a product of 1 gives a half period of 1
    always_comb begin
        case (con1_reg[B_FIRST_DIVIDER +: 2])
            2'b11:   pri = 7'd1;
            2'b10:   pri = 7'd4;
            2'b01:   pri = 7'd16;
            default: pri = 7'd64;
        endcase
        sec   = 4'(4'd8 - {1'b0, con1_reg[B_SECOND_DIVIDER +: 3]});
        div   = 10'(pri * sec);
        halfp = (div[9:1] == 9'd0) ? 9'd1 : div[9:1];
    end

    assign tick = (state_reg != ST_IDLE) && run && master && (div_cnt_reg == 9'(halfp - 1'b1));
    assign sync_seen = (ss_sync_reg[1] == con2_reg[B_FPOL]);
    assign selected = framed ? frame_arm_reg
                             : (!con1_reg[B_SELECT_PIN_USE] || !ss_sync_reg[1]);
    // Slave edges: leading edge leaves idle level
    assign s_lead  = (sck_sync_reg[1] != sck_prev_reg) && (sck_sync_reg[1] != cpol);
    assign s_trail = (sck_sync_reg[1] != sck_prev_reg) && (sck_sync_reg[1] == cpol);
    // Master waits on a frame slave sync; slave loads whenever selected
    assign load = (state_reg == ST_IDLE) && run &&
                  (master ? (tx_cnt != 4'h0) && (!(framed && fsd) || sync_seen)
                          : selected);

    // Change and sample points, per half clock as master or per pin edge as slave
    always_comb begin
        chg  = 1'b0;
        smpl = 1'b0;
        done = 1'b0;
        if (state_reg == ST_SHIFT && run) begin
            if (master) begin
                if (tick) begin
                    chg  = cke ? !n[0] : (n[0] && n != 6'd1);
                    smpl = sample_phase ? (cke ? !n[0] : (n[0] && n != 6'd1))
                               : (cke ? n[0] : !n[0]);
                    done = (n == 6'({nbits, 1'b0} + {5'h0, !cke && sample_phase}));
                end
            end else begin
                chg  = cke ? s_trail : (s_lead && !first_reg);
                smpl = cke ? s_lead : s_trail;
                done = smpl && (n == nbits);
            end
        end
    end

    // Shift engine: MSB first, one bit per shift clock
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            div_cnt_reg   <= 9'h0;
            half_cnt_reg  <= 6'h0;
            sh_tx_reg     <= 16'h0000;
            sh_rx_reg     <= 16'h0000;
            sck_act_reg   <= 1'b0;
            first_reg     <= 1'b0;
            done_reg      <= 1'b0;
        end else begin
            done_reg <= done;
            if (!port_on_reg) begin
                state_reg   <= ST_IDLE;
                sck_act_reg <= 1'b0;
            end else if (load) begin
                // An empty slave transmit side sends the word at its read slot, stale or never written
                sh_tx_reg    <= con1_reg[B_WIDE] ? tx_dout : {tx_dout[7:0], 8'h00};
                half_cnt_reg <= 6'h0;
                div_cnt_reg  <= 9'h0;
                first_reg    <= 1'b1;
                state_reg    <= (master && framed && !fsd && !con2_reg[B_FE]) ? ST_PRE
                                                                          : ST_SHIFT;
            end else if (run && state_reg != ST_IDLE) begin
                if (master) div_cnt_reg <= tick ? 9'h0 : 9'(div_cnt_reg + 1'b1);
                if (state_reg == ST_PRE) begin
                    // Sync pulse one bit time ahead of the first clock
                    if (tick) half_cnt_reg <= 6'(half_cnt_reg + 1'b1);
                    if (tick && n == 6'd2) begin
                        half_cnt_reg <= 6'h0;
                        state_reg    <= ST_SHIFT;
                    end
                end else begin
                    if (master && tick) begin
                        half_cnt_reg <= n;
                        if (n <= {nbits[4:0], 1'b0}) sck_act_reg <= !sck_act_reg;
                    end
                    if (!master && smpl) half_cnt_reg <= n;
                    if (!master && (s_lead || s_trail)) first_reg <= 1'b0;
                    if (chg) sh_tx_reg <= {sh_tx_reg[14:0], 1'b0};
                    if (smpl) sh_rx_reg <= {sh_rx_reg[14:0], sdi_sync_reg[1]};
                    if (done || (!master && !selected)) begin
                        state_reg   <= ST_IDLE;
                        sck_act_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // Frame slave gate: armed by the sync pulse, cleared by word end
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) frame_arm_reg <= 1'b0;
        else if (!framed || !port_on_reg || done) frame_arm_reg <= 1'b0;
        else if (sync_seen && state_reg == ST_IDLE) frame_arm_reg <= 1'b1;
    end

    // Standard mode limits both sides to one word
    word_fifo #(.DEPTH(DEPTH), .W(16)) u_tx_fifo (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .clr   (!port_on_reg),
        .limit (limit),
        .push  (wr_fire && awaddr_reg == ADDR_BUF && wstrb_reg[0]),
        .din   (wdata_reg),
        .pop   (load),
        .dout  (tx_dout),
        .count (tx_cnt)
    );

    word_fifo #(.DEPTH(DEPTH), .W(16)) u_rx_fifo (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .clr   (!port_on_reg),
        .limit (limit),
        .push  (done_reg),
        .din   (con1_reg[B_WIDE] ? sh_rx_reg : {8'h00, sh_rx_reg[7:0]}),
        .pop   (rd_pop),
        .dout  (rx_dout),
        .count (rx_cnt)
    );

    // Overflow: the arriving word is dropped by the full buffer; set beats clear
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) rx_overflow_reg <= 1'b0;
        else if (done_reg && rx_full) rx_overflow_reg <= 1'b1;
        else if (wr_fire && awaddr_reg == ADDR_STAT && wstrb_reg[0] && !wdata_reg[B_ROV])
            rx_overflow_reg <= 1'b0;
    end

    // Status view
    assign bec_src = master ? tx_cnt : rx_cnt;
    assign bec = (bec_src > 4'h7) ? 3'h7 : bec_src[2:0];
    assign stat_word = {port_on_reg, 1'b0, idle_halt_reg, 2'b00, bec,
                        state_reg == ST_IDLE,
                        rx_overflow_reg,
                        rx_cnt == 4'h0,
                        sel_reg, tx_full, rx_full};

    // Write side of the bus: address and data taken in either order
    assign wr_fire = aw_hold_reg && w_hold_reg && !BVALID;
    assign bm = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 16'h0000;
            wstrb_reg   <= 2'b00;
            AWREADY     <= 1'b0;
            WREADY      <= 1'b0;
            BVALID      <= 1'b0;
            BRESP       <= RESP_OKAY;
        end else begin
            AWREADY <= !aw_hold_reg && !(AWVALID && AWREADY) && !wr_fire;
            WREADY  <= !w_hold_reg && !(WVALID && WREADY) && !wr_fire;
            if (AWVALID && AWREADY) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= WDATA[15:0];
                wstrb_reg  <= WSTRB[1:0];
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                BVALID      <= 1'b1;
                BRESP       <= (awaddr_reg == ADDR_STAT || awaddr_reg == ADDR_CON1 ||
                                awaddr_reg == ADDR_CON2 || awaddr_reg == ADDR_BUF)
                               ? RESP_OKAY : RESP_SLVERR;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // Register stores honour byte strobes
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            con1_reg      <= CON1_RST;
            con2_reg      <= CON2_RST;
            port_on_reg   <= 1'b0;
            idle_halt_reg <= 1'b0;
            sel_reg       <= SEL_RST;
        end else if (wr_fire) begin
            if (awaddr_reg == ADDR_CON1)
                con1_reg <= (con1_reg & ~(bm & CON1_WMASK)) | (wdata_reg & bm & CON1_WMASK);
            if (awaddr_reg == ADDR_CON2)
                con2_reg <= (con2_reg & ~(bm & CON2_WMASK)) | (wdata_reg & bm & CON2_WMASK);
            if (awaddr_reg == ADDR_STAT && wstrb_reg[1]) begin
                port_on_reg   <= wdata_reg[B_ON];
                idle_halt_reg <= wdata_reg[B_SIDL];
            end
            if (awaddr_reg == ADDR_STAT && wstrb_reg[0]) sel_reg <= wdata_reg[B_SEL +: 3];
        end
    end

    // Read side: one read at a time; a buffer read pops the receive side
    assign rd_take = ARVALID && ARREADY;
    assign rd_pop  = rd_take && ARADDR == ADDR_BUF;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !rd_take;
            if (rd_take) begin
                RVALID <= 1'b1;
                RRESP  <= RESP_OKAY;
                case (ARADDR)
                    ADDR_STAT: RDATA <= {16'h0000, stat_word};
                    ADDR_CON1: RDATA <= {16'h0000, con1_reg};
                    ADDR_CON2: RDATA <= {16'h0000, con2_reg};
                    ADDR_BUF:  RDATA <= {16'h0000, rx_dout};
                    default: begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= RESP_SLVERR;
                    end
                endcase
            end else if (RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // Event selection; standard mode signals each received word
    always_comb begin
        case (sel_reg)
            SEL_TX_FULL:  ev = tx_full;
            SEL_TX_EMPTY: ev = load && master && tx_cnt == 4'h1;
            SEL_TX_DONE:  ev = done_reg && tx_cnt == 4'h0;
            SEL_TX_SLOT:  ev = load && tx_cnt != 4'h0;
            SEL_RX_FULL:  ev = rx_full;
            SEL_RX_3Q:    ev = rx_cnt >= 4'((DEPTH * 3) / 4);
            SEL_RX_ANY:   ev = rx_cnt != 4'h0;
            default:      ev = rd_pop && rx_cnt == 4'h1;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) EVENT_OUT <= 1'b0;
        else EVENT_OUT <= port_on_reg && (fifo_on ? ev : done_reg);
    end

    // Pin drive; released pins fall back to the general port logic
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PINS <= '0;
        end else begin
            PINS.sck_o  <= cpol ^ (master && sck_act_reg);
            PINS.sck_oe <= port_on_reg && master && !con1_reg[B_DSCK];
            PINS.sdo_o  <= sh_tx_reg[15];
            PINS.sdo_oe <= port_on_reg && !con1_reg[B_DSDO] && (master || selected);
            PINS.ss_o   <= (state_reg == ST_PRE ||
                            (con2_reg[B_FE] && state_reg == ST_SHIFT && half_cnt_reg < 6'd2))
                           ? con2_reg[B_FPOL] : !con2_reg[B_FPOL];
            PINS.ss_oe  <= port_on_reg && master && framed && !fsd;
        end
    end
endmodule // spi_port_with_fifo

/* logic/spi_port_pkg.sv */
package spi_port_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_STAT = 8'h00;
    localparam logic [7:0] ADDR_CON1 = 8'h04;
    localparam logic [7:0] ADDR_CON2 = 8'h08;
    localparam logic [7:0] ADDR_BUF  = 8'h0c;
    // Status and control field positions
    localparam int B_ON   = 15;
    localparam int B_SIDL = 13;
    localparam int B_ROV  = 6;
    localparam int B_SEL  = 2;
    // Control one field positions
    localparam int B_DSCK = 12;
    localparam int B_DSDO = 11;
    localparam int B_WIDE = 10;
    localparam int B_SMP  = 9;
    localparam int B_CKE  = 8;
    localparam int B_SELECT_PIN_USE = 7;
    localparam int B_CKP  = 6;
    localparam int B_MST  = 5;
    localparam int B_SECOND_DIVIDER = 2;
    localparam int B_FIRST_DIVIDER = 0;
    // Control two field positions
    localparam int B_FRM  = 15;
    localparam int B_FSD  = 14;
    localparam int B_FPOL = 13;
    localparam int B_FE   = 1;
    localparam int B_BEN  = 0;
    // Reset values and writable masks
    localparam logic [15:0] CON1_RST   = 16'h0000;
    localparam logic [15:0] CON2_RST   = 16'h0000;
    localparam logic [15:0] CON1_WMASK = 16'h1fff;
    localparam logic [15:0] CON2_WMASK = 16'he003;
    localparam logic [2:0]  SEL_RST    = 3'h0;
    // Buffer depth and event selections
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] SEL_TX_FULL  = 3'h7;
    localparam logic [2:0] SEL_TX_EMPTY = 3'h6;
    localparam logic [2:0] SEL_TX_DONE  = 3'h5;
    localparam logic [2:0] SEL_TX_SLOT  = 3'h4;
    localparam logic [2:0] SEL_RX_FULL  = 3'h3;
    localparam logic [2:0] SEL_RX_3Q    = 3'h2;
    localparam logic [2:0] SEL_RX_ANY   = 3'h1;
    localparam logic [2:0] SEL_RX_DRAIN = 3'h0;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PRE   = 2'b01,
        ST_SHIFT = 2'b10
    } eng_state_type;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
        logic ss_o;
        logic ss_oe;
    } pin_out_type;
endpackage

/* tb/spi_port_with_fifo_assertions.sv */
`timescale 1ns/1ps
module spi_port_checks (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [1:0]  BRESP,
    input wire logic [31:0] RDATA
);
    // Register access timing; the reset window masks the settling edges
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    a_wresp_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped early");
    a_rdata_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer changed early");
    a_wresp_time: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer late");
    a_rdata_time: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    a_wresp_done: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write answer repeated");
    a_rdata_done: assert property (RVALID && RREADY |=> !RVALID)
        else $error("read answer repeated");
    a_write_block: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("second write taken early");
    a_read_block: assert property (RVALID |-> !ARREADY)
        else $error("second read taken early");
endmodule // spi_port_checks
bind spi_port_with_fifo spi_port_checks u_chk (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .AWVALID  (AWVALID),
    .AWREADY  (AWREADY),
    .WVALID   (WVALID),
    .WREADY   (WREADY),
    .BVALID   (BVALID),
    .BREADY   (BREADY),
    .ARVALID  (ARVALID),
    .ARREADY  (ARREADY),
    .RVALID   (RVALID),
    .RREADY   (RREADY),
    .BRESP    (BRESP),
    .RDATA    (RDATA)
);

/* tb/spi_far_slave.sv */
`timescale 1ns/1ps
module spi_far_slave (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [2:0] bit_reg = 3'h0;
    logic [2:0] out_reg = 3'h0;
    // Capture on the leading edge, most significant bit first
    always @(posedge sck) begin
        rx_byte <= {rx_byte[6:0], mosi};
        bit_reg <= bit_reg + 3'h1;
    end
    // Move only on the trailing edge so data never shifts under the sample
    always @(negedge sck) out_reg <= bit_reg;
    // One driver for the line; between words the next first bit shows at once
    assign miso = tx_byte[3'h7 - out_reg];
endmodule // spi_far_slave

/* tb/spi_port_with_fifo_tb_top.sv */
`timescale 1ns/1ps
module spi_port_with_fifo_tb_top;
    import spi_port_pkg::*;
    logic        CORE_CLK = 1'b0, RST_N = 1'b0, IDLE_MODE = 1'b0, miso, EVENT_OUT;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00, far_tx = 8'h00, far_rx, b;
    logic [31:0] WDATA = 32'h0, RDATA, s;
    logic [3:0]  WSTRB = 4'h0;
    logic [1:0]  BRESP, RRESP, r;
    pin_out_type PINS;
    int          errors = 0, check_count = 0, seed = 59, ev_count = 0;
    always #12.5 CORE_CLK = ~CORE_CLK;
    // Standard mode gives one event pulse per received word
    always @(posedge CORE_CLK) if (EVENT_OUT === 1'b1) ev_count <= ev_count + 1;
    spi_port_with_fifo dut (.*, .SHIFT_CLOCK_PIN_IN(PINS.sck_o), .SERIAL_IN_PIN(miso),
        .SELECT_SYNC_PIN_IN(1'b1));
    spi_far_slave u_far (.sck(PINS.sck_o), .mosi(PINS.sdo_o), .tx_byte(far_tx), .miso(miso),
        .rx_byte(far_rx));
    // Bus write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        {AWADDR, WDATA, WSTRB} <= {a, d, 4'hf};
        {AWVALID, WVALID, BREADY} <= 3'b111;
        fork
            begin do @(posedge CORE_CLK); while (!AWREADY); AWVALID <= 1'b0; end
            begin do @(posedge CORE_CLK); while (!WREADY); WVALID <= 1'b0; end
        join
        while (!BVALID) @(posedge CORE_CLK);
        BREADY <= 1'b0;
    endtask
    // Bus read; data and response land in s and r
    task automatic rd(input logic [7:0] a);
        @(posedge CORE_CLK);
        {ARADDR, ARVALID, RREADY} <= {a, 2'b11};
        do @(posedge CORE_CLK); while (!ARREADY);
        ARVALID <= 1'b0;
        do @(posedge CORE_CLK); while (!RVALID);
        s = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Poll a status bit; bounded so a dead port shows as a mismatch
    task automatic wait_bit(input int n);
        s = 32'h0;
        for (int i = 0; i < 100 && !s[n]; i++) rd(ADDR_STAT);
    endtask
    task automatic print_verdict();
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog well beyond the few thousand cycles the run needs
    initial begin
        #500us;
        errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        rd(ADDR_CON2);
        chk("con2 reset", {16'h0, CON2_RST}, s);
        rd(8'h10);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        // Master, 8-bit, change on trailing edge, 16 x 1 prescale
        wr(ADDR_CON1, 32'h013d);
        wr(ADDR_STAT, 32'h8000);
        for (int i = 0; i < 6; i++) begin
            b = (i == 0) ? 8'hff : 8'($random(seed));
            far_tx = (i == 1) ? 8'h00 : 8'($random(seed));
            wr(ADDR_BUF, {24'h0, b});
            wait_bit(0);
            chk("rx full set", 1, s[0]);
            rd(ADDR_BUF);
            chk("word in", {24'h0, far_tx}, s);
            chk("word out", {24'h0, b}, {24'h0, far_rx});
            rd(ADDR_STAT);
            chk("rx full clear", 0, s[0]);
        end
        // Idle master: clock at idle level and driven, data out driven, no sync drive
        chk("pin drive", 32'h6, {28'h0, PINS.sck_o, PINS.sck_oe, PINS.sdo_oe, PINS.ss_oe});
        // Idle halt: a written word waits until the CPU leaves idle
        wr(ADDR_STAT, 32'ha000);
        IDLE_MODE <= 1'b1;
        wr(ADDR_BUF, 32'h3c);
        repeat (40) @(posedge CORE_CLK);
        rd(ADDR_STAT);
        chk("halted tx full", 1, s[1]);
        chk("halted shifter empty", 1, s[7]);
        IDLE_MODE <= 1'b0;
        wait_bit(0);
        rd(ADDR_BUF);
        chk("word after idle", {24'h0, far_tx}, s);
        chk("word out after idle", 32'h3c, {24'h0, far_rx});
        // Second word arrives while the first is unread; it carries other bits
        wr(ADDR_BUF, 32'h5a);
        wait_bit(0);
        b = far_tx;
        far_tx = ~far_tx;
        wr(ADDR_BUF, 32'ha5);
        wait_bit(B_ROV);
        chk("overflow set", 1, s[B_ROV]);
        rd(ADDR_BUF);
        chk("first word kept", {24'h0, b}, s);
        wr(ADDR_STAT, 32'h8000);
        rd(ADDR_STAT);
        chk("overflow clear", 0, s[B_ROV]);
        chk("event pulses", 32'd9, ev_count);
        print_verdict();
    end
endmodule // spi_port_with_fifo_tb_top
